/* jtd_pkg.sv */
// Package for the test access port data-register block: codes, states, layouts.
package jtd_pkg;

  // Instruction codes
  localparam logic [3:0] INSTR_EXTEST = 4'h0;
  localparam logic [3:0] INSTR_CHAIN_SELECT = 4'h2;
  localparam logic [3:0] INSTR_SAMPLE_PRELOAD = 4'h3;
  localparam logic [3:0] INSTR_RESUME = 4'h4;
  localparam logic [3:0] INSTR_CLAMP = 4'h5;
  localparam logic [3:0] INSTR_HIGHZ = 4'h7;
  localparam logic [3:0] INSTR_CLAMPZ = 4'h9;
  localparam logic [3:0] INSTR_INTEST = 4'hC;
  localparam logic [3:0] INSTR_IDCODE = 4'hE;
  localparam logic [3:0] INSTR_BYPASS = 4'hF;

  // Capture values and reset values
  localparam logic [3:0] IR_CAPTURE_VALUE = 4'h1;
  localparam logic [4:0] CHAIN_CAPTURE_VALUE = 5'h10;
  localparam logic [4:0] CHAIN_RESET_VALUE = 5'h03;
  localparam logic BYPASS_CAPTURE_VALUE = 1'b0;

  // Widths
  localparam int IR_WIDTH = 4;
  localparam int CHAIN_WIDTH = 5;
  localparam int ID_WIDTH = 32;

  // Identification layout
  localparam int ID_REV_MSB = 31;
  localparam int ID_REV_LSB = 28;
  localparam int ID_PART_MSB = 27;
  localparam int ID_PART_LSB = 12;
  localparam int ID_MAKER_MSB = 11;
  localparam int ID_MAKER_LSB = 1;
  localparam int ID_FIXED_BIT = 0;

  // Chain numbers
  localparam logic [4:0] CHAIN_CORE_SCAN = 5'h00;
  localparam logic [4:0] CHAIN_DEBUG = 5'h01;
  localparam logic [4:0] CHAIN_BKPT_PROG = 5'h02;
  localparam logic [4:0] CHAIN_EXT_BOUNDARY = 5'h03;
  localparam logic [4:0] CHAIN_TAG_RAM = 5'h04;
  localparam logic [4:0] CHAIN_RESERVED_5 = 5'h05;
  localparam logic [4:0] CHAIN_TRACE = 5'h06;
  localparam logic [4:0] CHAIN_RESERVED_LO = 5'h07;
  localparam logic [4:0] CHAIN_RESERVED_HI = 5'h0E;
  localparam logic [4:0] CHAIN_SYS_COPROC = 5'h0F;
  localparam logic [4:0] CHAIN_UNASSIGNED_LO = 5'h10;

  // Controller states, Gray-ordered along the DR path
  typedef enum logic [3:0] {
    JTD_RESET = 4'h0,
    JTD_IDLE = 4'h1,
    JTD_SEL_DR = 4'h3,
    JTD_CAP_DR = 4'h2,
    JTD_SHIFT_DR = 4'h6,
    JTD_EXIT1_DR = 4'h7,
    JTD_PAUSE_DR = 4'h5,
    JTD_EXIT2_DR = 4'h4,
    JTD_UPD_DR = 4'hC,
    JTD_SEL_IR = 4'hD,
    JTD_CAP_IR = 4'hF,
    JTD_SHIFT_IR = 4'hE,
    JTD_EXIT1_IR = 4'hA,
    JTD_PAUSE_IR = 4'hB,
    JTD_EXIT2_IR = 4'h9,
    JTD_UPD_IR = 4'h8
  } jtd_state_t;

  // Serial pins as one group
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } jtd_pins_t;

  // Per-edge controls from the state machine
  typedef struct packed {
    logic rise;
    logic fall;
    logic cap_dr;
    logic shift_dr;
    logic upd_dr;
    logic cap_ir;
    logic shift_ir;
    logic upd_ir;
    logic idle;
    logic reset;
  } jtd_ctl_t;

endpackage : jtd_pkg

/* jtd_pin_sync.sv */
// Two-stage synchroniser for the serial pins plus TCK edge detection.
`timescale 1ns/1ns
module jtd_pin_sync (
  input wire logic clock,
  input wire logic rst_b,
  input wire jtd_pkg::jtd_pins_t pins_async,
  output jtd_pkg::jtd_pins_t pins,
  output logic tck_rise,
  output logic tck_fall
);
  jtd_pkg::jtd_pins_t stage_one;
  logic tck_prev;

  // First stage feeds only the second; edges come from the second onward
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      stage_one <= '0;
      pins <= '0;
      tck_prev <= 1'b0;
    end else begin
      stage_one <= pins_async;
      pins <= stage_one;
      tck_prev <= pins.tck;
    end
  end

  // Edges as one-cycle strobes on the system clock
  assign tck_rise = pins.tck & ~tck_prev;
  assign tck_fall = ~pins.tck & tck_prev;
endmodule : jtd_pin_sync

/* jtd_tap_fsm.sv */
// Sixteen-state test access port controller stepped on TCK rising edges.
`timescale 1ns/1ns
module jtd_tap_fsm (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic tck_rise,
  input wire logic tms,
  input wire logic trst_b,
  output jtd_pkg::jtd_state_t state
);
  jtd_pkg::jtd_state_t next_state;

  // Standard next-state table driven by TMS
  always_comb begin
    next_state = state;
    unique case (state)
      jtd_pkg::JTD_RESET: next_state = tms ? jtd_pkg::JTD_RESET : jtd_pkg::JTD_IDLE;
      jtd_pkg::JTD_IDLE: next_state = tms ? jtd_pkg::JTD_SEL_DR : jtd_pkg::JTD_IDLE;
      jtd_pkg::JTD_SEL_DR: next_state = tms ? jtd_pkg::JTD_SEL_IR : jtd_pkg::JTD_CAP_DR;
      jtd_pkg::JTD_CAP_DR: next_state = tms ? jtd_pkg::JTD_EXIT1_DR : jtd_pkg::JTD_SHIFT_DR;
      jtd_pkg::JTD_SHIFT_DR: next_state = tms ? jtd_pkg::JTD_EXIT1_DR : jtd_pkg::JTD_SHIFT_DR;
      jtd_pkg::JTD_EXIT1_DR: next_state = tms ? jtd_pkg::JTD_UPD_DR : jtd_pkg::JTD_PAUSE_DR;
      jtd_pkg::JTD_PAUSE_DR: next_state = tms ? jtd_pkg::JTD_EXIT2_DR : jtd_pkg::JTD_PAUSE_DR;
      jtd_pkg::JTD_EXIT2_DR: next_state = tms ? jtd_pkg::JTD_UPD_DR : jtd_pkg::JTD_SHIFT_DR;
      jtd_pkg::JTD_UPD_DR: next_state = tms ? jtd_pkg::JTD_SEL_DR : jtd_pkg::JTD_IDLE;
      jtd_pkg::JTD_SEL_IR: next_state = tms ? jtd_pkg::JTD_RESET : jtd_pkg::JTD_CAP_IR;
      jtd_pkg::JTD_CAP_IR: next_state = tms ? jtd_pkg::JTD_EXIT1_IR : jtd_pkg::JTD_SHIFT_IR;
      jtd_pkg::JTD_SHIFT_IR: next_state = tms ? jtd_pkg::JTD_EXIT1_IR : jtd_pkg::JTD_SHIFT_IR;
      jtd_pkg::JTD_EXIT1_IR: next_state = tms ? jtd_pkg::JTD_UPD_IR : jtd_pkg::JTD_PAUSE_IR;
      jtd_pkg::JTD_PAUSE_IR: next_state = tms ? jtd_pkg::JTD_EXIT2_IR : jtd_pkg::JTD_PAUSE_IR;
      jtd_pkg::JTD_EXIT2_IR: next_state = tms ? jtd_pkg::JTD_UPD_IR : jtd_pkg::JTD_SHIFT_IR;
      jtd_pkg::JTD_UPD_IR: next_state = tms ? jtd_pkg::JTD_SEL_DR : jtd_pkg::JTD_IDLE;
    endcase
  end

  // Test reset is applied on every system clock, not qualified by the TCK strobe like TMS, so it needs no TCK edge to act
  always_ff @(posedge clock) begin
    if (!rst_b || !trst_b) begin
      state <= jtd_pkg::JTD_RESET;
    end else if (tck_rise) begin
      state <= next_state; // see [R27]
    end
  end
endmodule : jtd_tap_fsm

/* jtd_tap_data_regs.sv */
// Test access port data registers: instruction, bypass, identification, chain select.
//
// Functional notes
// [R1] Sample/preload keeps every scan cell of the chosen chain in system mode.
// [R2] Sample/preload Capture-DR snapshots boundary signals on TCK rise, system undisturbed.
// [R3] Sample/preload shifts snapshot out; preload never reaches system while active.
// [R4] Controller preloads boundary data before choosing INTEST or EXTEST.
// [R5] Debug-resume puts bypass between TDI and TDO, otherwise acts as BYPASS.
// [R6] Debug-resume plus Run-Test/Idle makes processor leave debug state.
// [R7] Bypass is one stage, no parallel output, one TCK delay.
// [R8] Bypass captures constant zero in Capture-DR.
// [R9] IDCODE selects 32-bit identification register loaded from input bus.
// [R10] Identification layout: revision, part number, maker, bit zero one.
// [R11] Four-bit instruction register forms the path during Shift-IR.
// [R12] Capture-IR loads 0001; shifting is least significant bit first.
// [R13] Update-IR makes the shifted value the current instruction.
// [R14] Test reset makes IDCODE the current instruction.
// [R15] Five-bit chain select forms the path in Shift-DR under chain-select.
// [R16] Chain select captures 10000; shifting is least significant bit first.
// [R17] Update-DR value chooses the active chain for later instructions.
// [R18] Active chain changes only by chain-select or reset; reset picks 3.
// [R19] Active chain, instruction, state and TCK phases driven out continuously.
// [R20] External chain gets serial data out and returns it on return input.
// [R21] External chain path used for chain 3 and unassigned numbers.
// [R22] Surrounding design multiplexes several external chains onto the return.
// [R23] Chain numbers 0,1,2,3,4,6,15 assigned; 5, 7:14 reserved; 16:31 unassigned.
// [R24] TDI and TMS sampled on TCK rise; TDO changes on TCK fall.
// [R25] Undefined instruction codes behave as BYPASS.
// [R26] Chain-select is 0010, IDCODE 1110, BYPASS 1111.
// [R27] Sequencing follows the standard sixteen-state controller.
`timescale 1ns/1ns
module jtd_tap_data_regs (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic trst_b,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_en,
  input wire logic [31:0] id_value_input_bus,
  input wire logic core_chain_serial_return,
  input wire logic external_chain_serial_return,
  output logic external_chain_serial_out,
  output logic [4:0] active_chain_number_out,
  output logic [3:0] current_instr_out,
  output logic [3:0] controller_state_out,
  output logic test_clock_phase_one,
  output logic test_clock_phase_two,
  output logic boundary_test_mode,
  output logic boundary_capture,
  output logic boundary_shift,
  output logic boundary_update,
  output logic debug_resume
);

  // Selection of the serial path
  typedef enum logic [2:0] {
    JTD_PATH_BYPASS = 3'h0,
    JTD_PATH_IDCODE = 3'h1,
    JTD_PATH_CHAIN = 3'h3,
    JTD_PATH_SCAN = 3'h2
  } jtd_path_t;

  // Pins, state and edge strobes
  jtd_pkg::jtd_pins_t pins;
  jtd_pkg::jtd_pins_t pins_async;
  jtd_pkg::jtd_state_t state;
  jtd_pkg::jtd_ctl_t ctl;
  logic tck_rise;
  logic tck_fall;

  // Test reset synchroniser
  logic trst_meta;
  logic trst_sync_b;

  // Shift stages and holding registers
  logic [3:0] instr_shift;
  logic [3:0] instruction_holding;
  logic bypass_stage;
  logic [31:0] device_identification;
  logic [4:0] chain_shift;
  logic [4:0] chain_selection;

  // Serial source and chain returns
  logic serial_tap;
  logic ext_return_meta;
  logic ext_return;
  logic core_return_meta;
  logic core_return;

  // Decodes
  logic chain_is_external;
  logic instr_is_boundary_test;
  logic [31:0] id_capture;
  jtd_path_t dr_path;

  // Decide whether a chain number is served by the external serial path
  // Reserved numbers stay on the core path
  function automatic logic chain_external(input logic [4:0] num);
    chain_external = (num == jtd_pkg::CHAIN_EXT_BOUNDARY)
      || (num >= jtd_pkg::CHAIN_UNASSIGNED_LO); // see [R21] see [R23]
  endfunction : chain_external

  // Map an instruction code onto the register it puts between TDI and TDO
  function automatic jtd_path_t instr_path(input logic [3:0] code);
    unique case (code)
      jtd_pkg::INSTR_IDCODE: instr_path = JTD_PATH_IDCODE; // see [R9]
      jtd_pkg::INSTR_CHAIN_SELECT: instr_path = JTD_PATH_CHAIN; // see [R15] see [R26]
      jtd_pkg::INSTR_EXTEST,
      jtd_pkg::INSTR_INTEST,
      jtd_pkg::INSTR_SAMPLE_PRELOAD: instr_path = JTD_PATH_SCAN;
      default: instr_path = JTD_PATH_BYPASS; // see [R5] see [R25]
    endcase
  endfunction : instr_path

  assign pins_async = '{tck: tck, tms: tms, tdi: tdi};

  jtd_pin_sync u_sync (
    .clock(clock),
    .rst_b(rst_b),
    .pins_async(pins_async),
    .pins(pins),
    .tck_rise(tck_rise),
    .tck_fall(tck_fall)
  );

  jtd_tap_fsm u_fsm (
    .clock(clock),
    .rst_b(rst_b),
    .tck_rise(tck_rise),
    .tms(pins.tms),
    .trst_b(trst_sync_b),
    .state(state)
  );

  // Test reset and scan returns come from outside the clock domain
  // Held test reset keeps the controller in reset
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      trst_meta <= 1'b0;
      trst_sync_b <= 1'b0;
      ext_return_meta <= 1'b0;
      ext_return <= 1'b0;
      core_return_meta <= 1'b0;
      core_return <= 1'b0;
    end else begin
      trst_meta <= trst_b;
      trst_sync_b <= trst_meta;
      ext_return_meta <= external_chain_serial_return;
      ext_return <= ext_return_meta;
      core_return_meta <= core_chain_serial_return;
      core_return <= core_return_meta;
    end
  end

  // State decodes, qualified with the rising TCK strobe
  // Reset is a level: holding registers are reloaded with IDCODE and chain 3 on every clock while in reset
  assign ctl.rise = tck_rise; // see [R24]
  assign ctl.fall = tck_fall;
  assign ctl.cap_dr = tck_rise && (state == jtd_pkg::JTD_CAP_DR);
  assign ctl.shift_dr = tck_rise && (state == jtd_pkg::JTD_SHIFT_DR);
  assign ctl.upd_dr = tck_rise && (state == jtd_pkg::JTD_UPD_DR);
  assign ctl.cap_ir = tck_rise && (state == jtd_pkg::JTD_CAP_IR);
  assign ctl.shift_ir = tck_rise && (state == jtd_pkg::JTD_SHIFT_IR);
  assign ctl.upd_ir = tck_rise && (state == jtd_pkg::JTD_UPD_IR);
  assign ctl.idle = tck_rise && (state == jtd_pkg::JTD_IDLE);
  assign ctl.reset = state == jtd_pkg::JTD_RESET;

  assign dr_path = instr_path(instruction_holding);
  assign chain_is_external = chain_external(chain_selection);
  // Only INTEST and EXTEST put cells in test mode; preload stays latched away
  assign instr_is_boundary_test = (instruction_holding == jtd_pkg::INSTR_EXTEST)
    || (instruction_holding == jtd_pkg::INSTR_INTEST); // see [R1] see [R3]

  // Bit zero forced high whatever the tie-off holds
  always_comb begin
    id_capture = id_value_input_bus;
    id_capture[jtd_pkg::ID_FIXED_BIT] = 1'b1; // see [R10]
  end

  // Instruction shift stage: capture 0001, shift in at the top, out at bit 0
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      instr_shift <= jtd_pkg::IR_CAPTURE_VALUE;
    end else if (ctl.cap_ir) begin
      instr_shift <= jtd_pkg::IR_CAPTURE_VALUE; // see [R12]
    end else if (ctl.shift_ir) begin
      instr_shift <= {pins.tdi, instr_shift[3:1]}; // see [R11] see [R12]
    end
  end

  // Current instruction: update on Update-IR, IDCODE whenever in reset
  // Shifted bits reach the decoders only at Update-IR
  always_ff @(posedge clock) begin
    if (!rst_b || ctl.reset) begin
      instruction_holding <= jtd_pkg::INSTR_IDCODE; // see [R14]
    end else if (ctl.upd_ir) begin
      instruction_holding <= instr_shift; // see [R13]
    end
  end

  // Single bypass stage, no parallel output
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      bypass_stage <= jtd_pkg::BYPASS_CAPTURE_VALUE;
    end else if (ctl.cap_dr && dr_path == JTD_PATH_BYPASS) begin
      bypass_stage <= jtd_pkg::BYPASS_CAPTURE_VALUE; // see [R8]
    end else if (ctl.shift_dr && dr_path == JTD_PATH_BYPASS) begin
      bypass_stage <= pins.tdi; // see [R7]
    end
  end

  // Identification register; the input bus carries the full layout
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      device_identification <= '0;
    end else if (ctl.cap_dr && dr_path == JTD_PATH_IDCODE) begin
      device_identification <= id_capture; // see [R9] see [R10]
    end else if (ctl.shift_dr && dr_path == JTD_PATH_IDCODE) begin
      device_identification <= {pins.tdi, device_identification[31:1]};
    end
  end

  // Chain select shift stage
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      chain_shift <= jtd_pkg::CHAIN_CAPTURE_VALUE;
    end else if (ctl.cap_dr && dr_path == JTD_PATH_CHAIN) begin
      chain_shift <= jtd_pkg::CHAIN_CAPTURE_VALUE; // see [R16]
    end else if (ctl.shift_dr && dr_path == JTD_PATH_CHAIN) begin
      chain_shift <= {pins.tdi, chain_shift[4:1]}; // see [R15] see [R16]
    end
  end

  // Active chain: only chain-select Update-DR or reset changes it
  // Values shifted under other instructions are dropped
  always_ff @(posedge clock) begin
    if (!rst_b || ctl.reset) begin
      chain_selection <= jtd_pkg::CHAIN_RESET_VALUE; // see [R18]
    end else if (ctl.upd_dr && dr_path == JTD_PATH_CHAIN) begin
      chain_selection <= chain_shift; // see [R17] see [R18]
    end
  end

  // Serial source chosen before the falling edge launches it
  // Internal and reserved chains share the core return
  always_comb begin
    serial_tap = bypass_stage;
    if (state == jtd_pkg::JTD_SHIFT_IR) begin
      serial_tap = instr_shift[0]; // see [R11]
    end else if (state == jtd_pkg::JTD_SHIFT_DR) begin
      unique case (dr_path)
        JTD_PATH_IDCODE: serial_tap = device_identification[0];
        JTD_PATH_CHAIN: serial_tap = chain_shift[0];
        JTD_PATH_SCAN: serial_tap = chain_is_external ? ext_return : core_return; // see [R20]
        JTD_PATH_BYPASS: serial_tap = bypass_stage; // see [R5]
      endcase
    end
  end

  // TDO and its enable change only on falling TCK
  // Fall strobe lags the pin by two clocks
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      tdo <= 1'b0;
      tdo_en <= 1'b0;
    end else if (ctl.fall) begin
      tdo <= serial_tap; // see [R24]
      tdo_en <= (state == jtd_pkg::JTD_SHIFT_DR) || (state == jtd_pkg::JTD_SHIFT_IR);
    end
  end

  // Status outputs and boundary controls for the chains outside
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      active_chain_number_out <= jtd_pkg::CHAIN_RESET_VALUE;
      current_instr_out <= jtd_pkg::INSTR_IDCODE;
      controller_state_out <= jtd_pkg::JTD_RESET;
      test_clock_phase_one <= 1'b0;
      test_clock_phase_two <= 1'b0;
      external_chain_serial_out <= 1'b0;
      boundary_test_mode <= 1'b0;
      boundary_capture <= 1'b0;
      boundary_shift <= 1'b0;
      boundary_update <= 1'b0;
      debug_resume <= 1'b0;
    end else begin
      active_chain_number_out <= chain_selection; // see [R19]
      current_instr_out <= instruction_holding; // see [R19]
      controller_state_out <= state; // see [R19]
      // Phases lag the pin by three clocks: two synchroniser stages plus this register
      test_clock_phase_one <= pins.tck; // see [R19]
      test_clock_phase_two <= ~pins.tck;
      external_chain_serial_out <= pins.tdi; // see [R20]
      boundary_test_mode <= instr_is_boundary_test && chain_is_external; // see [R1]
      boundary_capture <= ctl.cap_dr && dr_path == JTD_PATH_SCAN; // see [R2]
      boundary_shift <= ctl.shift_dr && dr_path == JTD_PATH_SCAN; // see [R3]
      // Preloaded data is applied only under the test instructions
      boundary_update <= ctl.upd_dr && instr_is_boundary_test; // see [R3]
      debug_resume <= ctl.idle && instruction_holding == jtd_pkg::INSTR_RESUME; // see [R6]
    end
  end

endmodule : jtd_tap_data_regs

/* jtd_tap_sva.sv */
// Concurrent checks on the ports of the test access port data-register block.
`timescale 1ns/1ns
module jtd_tap_sva (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic trst_b,
  input wire logic tck,
  input wire logic tdo,
  input wire logic tdo_en,
  input wire logic [4:0] active_chain_number_out,
  input wire logic [3:0] current_instr_out,
  input wire logic [3:0] controller_state_out,
  input wire logic test_clock_phase_one,
  input wire logic test_clock_phase_two,
  input wire logic boundary_test_mode,
  input wire logic boundary_capture,
  input wire logic boundary_shift,
  input wire logic boundary_update,
  input wire logic debug_resume
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);

  // Chain may only move under chain-select, or back to 3 on a reset
  chk_chain_only_select: assert property ($changed(active_chain_number_out) |->
    current_instr_out == jtd_pkg::INSTR_CHAIN_SELECT || active_chain_number_out == 5'h03)
    else $error("active chain changed outside chain-select");
  chk_reset_values: assert property ($rose(rst_b) |-> current_instr_out == 4'hE &&
    active_chain_number_out == 5'h03 && controller_state_out == 4'h0)
    else $error("reset values wrong");
  chk_test_reset: assert property ($fell(trst_b) |-> ##[1:8]
    (current_instr_out == jtd_pkg::INSTR_IDCODE && active_chain_number_out == 5'h03))
    else $error("test reset did not restore instruction and chain");
  // The synchroniser delay keeps tck low two clocks before a fall-launched change
  chk_tdo_on_fall: assert property ($changed(tdo) |-> !$past(tck, 2))
    else $error("serial output moved after a rising test clock");
  chk_tdo_en_shift: assert property ($rose(tdo_en) |->
    controller_state_out == jtd_pkg::JTD_SHIFT_DR || controller_state_out == jtd_pkg::JTD_SHIFT_IR)
    else $error("output enabled outside shift states");
  chk_resume_pulse: assert property (debug_resume |->
    current_instr_out == jtd_pkg::INSTR_RESUME ##1 !debug_resume)
    else $error("resume pulse without resume instruction or too long");
  chk_boundary_mode: assert property (boundary_test_mode |-> (current_instr_out == 4'h0 ||
    current_instr_out == 4'hC) && (active_chain_number_out == 5'h03 || active_chain_number_out[4]))
    else $error("boundary test mode under wrong instruction or chain");
  chk_capture_strobe: assert property (boundary_capture |->
    !boundary_shift && !boundary_update ##1 !boundary_capture)
    else $error("capture strobe overlaps or stretches");
  chk_phase_pair: assert property ($past(rst_b) |->
    test_clock_phase_two != test_clock_phase_one)
    else $error("clock phases not complementary");
endmodule : jtd_tap_sva

/* jtd_probe_model.sv */
// Behavioural test probe: drives the serial pins and reads the serial output.
`timescale 1ns/1ns
module jtd_probe_model (
  input wire logic clock,
  input wire logic tdo,
  output logic tck,
  output logic tms,
  output logic tdi
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end

  // One 160 ns test clock period, called at a falling system clock edge
  task automatic step(input logic m, input logic d, output logic q);
    tck = 1'b0;
    tms = m;
    tdi = d;
    repeat (4) @(negedge clock);
    tck = 1'b1;
    repeat (2) @(negedge clock);
    q = tdo;
    @(negedge clock);
    tdi = ~d; // Hold time over: show a changed level, not the old bit
    @(negedge clock); // Status outputs settle before the caller looks
  endtask : step

  // From Idle through one IR or DR scan, LSB first, back to Idle
  task automatic scan(input logic ir, input logic [31:0] din, input int n,
                      output logic [31:0] dout);
    logic q;
    dout = '0;
    step(1'b1, 1'b0, q);
    if (ir) step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
    step(1'b0, 1'b0, q);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
  endtask : scan

  // Five rising edges with the mode line high reach the reset state
  task automatic tms_reset();
    logic q;
    repeat (5) step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
  endtask : tms_reset
endmodule : jtd_probe_model

/* tb_top.sv */
// Self-checking testbench for the test access port data-register block.
`timescale 1ns/1ns
module tb_top;
  localparam logic [31:0] ID_VALUE = 32'h2A5C_3A4B; // Arbitrary identity, bit zero set
  logic clock = 1'b0;
  logic rst_b;
  logic trst_b;
  logic tck, tms, tdi, tdo, tdo_en, debug_resume;
  logic [31:0] id_value_input_bus = ID_VALUE;
  logic core_chain_serial_return = 1'b0;
  logic external_chain_serial_out, external_chain_serial_return;
  logic [4:0] active_chain_number_out;
  logic [3:0] current_instr_out, controller_state_out;
  logic test_clock_phase_one, test_clock_phase_two;
  logic boundary_test_mode, boundary_capture, boundary_shift, boundary_update;
  logic [3:0] ext_q = 4'h9;
  logic [31:0] d;
  logic q;
  int fail_count = 0;
  int comparisons = 0;
  int cap_n = 0, sh_n = 0, upd_n = 0, res_n = 0;

  always #10 clock = ~clock;

  jtd_tap_data_regs u_jtd_tap_data_regs (.clock, .rst_b, .trst_b, .tck, .tms, .tdi, .tdo,
    .tdo_en, .id_value_input_bus, .core_chain_serial_return, .external_chain_serial_return,
    .external_chain_serial_out, .active_chain_number_out, .current_instr_out,
    .controller_state_out, .test_clock_phase_one, .test_clock_phase_two, .boundary_test_mode,
    .boundary_capture, .boundary_shift, .boundary_update, .debug_resume);
  jtd_probe_model u_jtd_probe_model (.clock, .tdo, .tck, .tms, .tdi);

  // Four-stage external chain stepped by the shift strobe, plus strobe tallies
  assign external_chain_serial_return = ext_q[0];
  always @(posedge clock) begin
    if (boundary_shift) ext_q <= {external_chain_serial_out, ext_q[3:1]};
    cap_n <= cap_n + boundary_capture;
    sh_n <= sh_n + boundary_shift;
    upd_n <= upd_n + boundary_update;
    res_n <= res_n + debug_resume;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic final_report();
    $display("checks %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : final_report

  task automatic load_ir(input logic [3:0] code);
    u_jtd_probe_model.scan(1'b1, {28'h0, code}, 4, d);
    check(d[3:0], 4'h1, "captured instruction");
    check(current_instr_out, code, "current instruction");
  endtask : load_ir

  task automatic t_ident();
    check(current_instr_out, 4'hE, "instruction after reset");
    load_ir(jtd_pkg::INSTR_IDCODE);
    u_jtd_probe_model.scan(1'b0, 32'h0, 32, d);
    check(d, ID_VALUE, "identification shifted out");
    check(d[0], 1'b1, "identification fixed bit");
    check({test_clock_phase_one, test_clock_phase_two, tdo_en}, 3'h4, "phases");
  endtask : t_ident

  // Bypass-like codes: one stage, captured zero shifted out first
  task automatic t_bypass();
    logic [3:0] codes [8] = '{4'hF, 4'h4, 4'h1, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9};
    for (int i = 0; i < 8; i++) begin
      load_ir(codes[i]);
      u_jtd_probe_model.scan(1'b0, 32'h0000_00B5, 8, d);
      check(d[7:0], 8'h6A, "bypass stream");
    end
  endtask : t_bypass

  task automatic select_chain(input logic [4:0] num);
    load_ir(jtd_pkg::INSTR_CHAIN_SELECT);
    u_jtd_probe_model.scan(1'b0, {27'h0, num}, 5, d);
    check(d[4:0], 5'h10, "chain select capture");
    check(active_chain_number_out, num, "active chain");
  endtask : select_chain

  // Known boundary data goes in under sample/preload before a test instruction
  task automatic enter_test(input logic [3:0] code);
    load_ir(jtd_pkg::INSTR_SAMPLE_PRELOAD);
    u_jtd_probe_model.scan(1'b0, 32'h0000_00C5, 8, d);
    load_ir(code);
  endtask : enter_test

  task automatic t_chain();
    int c0, s0, u0;
    select_chain(5'h07);
    enter_test(jtd_pkg::INSTR_EXTEST);
    check(active_chain_number_out, 5'h07, "chain kept");
    check(boundary_test_mode, 1'b0, "reserved chain not external");
    select_chain(5'h14);
    enter_test(jtd_pkg::INSTR_INTEST);
    check(boundary_test_mode, 1'b1, "unassigned chain external");
    select_chain(5'h03);
    load_ir(jtd_pkg::INSTR_SAMPLE_PRELOAD);
    check(boundary_test_mode, 1'b0, "sample keeps system mode");
    c0 = cap_n;
    s0 = sh_n;
    u0 = upd_n;
    u_jtd_probe_model.scan(1'b0, 32'h0000_00C5, 8, d);
    // Outside chain holds 4'hC from the last preload, then the new bits follow
    check(d[7:0], 8'h5C, "external chain stream");
    check(cap_n - c0, 1, "capture strobes");
    check(sh_n - s0, 8, "shift strobes");
    check(upd_n - u0, 0, "preload kept from system");
    check(boundary_test_mode, 1'b0, "preload stays off system");
  endtask : t_chain

  task automatic t_resume();
    int r0;
    r0 = res_n;
    load_ir(jtd_pkg::INSTR_RESUME);
    u_jtd_probe_model.step(1'b0, 1'b0, q);
    check(res_n != r0, 1'b1, "resume pulse in idle");
  endtask : t_resume

  task automatic t_resets();
    select_chain(5'h05);
    load_ir(jtd_pkg::INSTR_BYPASS);
    u_jtd_probe_model.tms_reset();
    check(current_instr_out, 4'hE, "mode-line reset instruction");
    check(active_chain_number_out, 5'h03, "mode-line reset chain");
    select_chain(5'h01);
    @(negedge clock);
    trst_b = 1'b0;
    repeat (8) @(negedge clock);
    trst_b = 1'b1;
    repeat (2) @(negedge clock);
    check(current_instr_out, 4'hE, "test reset instruction");
    check(active_chain_number_out, 5'h03, "test reset chain");
    check(controller_state_out, 4'h0, "test reset state");
  endtask : t_resets

  // Main sequence: reset for 8 clocks, then every scenario in turn
  initial begin
    rst_b = 1'b0;
    trst_b = 1'b1;
    repeat (8) @(negedge clock);
    rst_b = 1'b1;
    repeat (4) @(negedge clock);
    u_jtd_probe_model.step(1'b0, 1'b0, q);
    t_ident();
    t_bypass();
    t_chain();
    t_resume();
    t_resets();
    final_report();
  end

  // Hang guard: a run that overstays counts as a mismatch
  initial begin
    repeat (100000) @(posedge clock);
    fail_count++;
    final_report();
  end
endmodule : tb_top

bind jtd_tap_data_regs jtd_tap_sva u_jtd_tap_sva (.clock, .rst_b, .trst_b, .tck, .tdo, .tdo_en,
  .active_chain_number_out, .current_instr_out, .controller_state_out, .test_clock_phase_one,
  .test_clock_phase_two, .boundary_test_mode, .boundary_capture, .boundary_shift,
  .boundary_update, .debug_resume);
